// file: verilog/ssi_pkg.sv
package ssi_pkg;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CFG_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] POS_OFS = 8'h0C;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int SEL_LSB = 0;
    localparam int CODE_BIT = 4;
    localparam int PER_LSB = 8;
    localparam int MODE_LSB = 16;
    localparam int MT_LSB = 0;
    localparam int ST_LSB = 8;
    localparam logic [3:0] SEL_SSI = 4'h2;
    localparam logic [3:0] SEL_RST = 4'h0;
    localparam logic CODE_BIN = 1'b0;
    localparam logic CODE_GRAY = 1'b1;
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [7:0] PER_RST = 8'h01;
    localparam logic [4:0] MT_MAX = 5'h0E;
    localparam logic [4:0] MT_RST = 5'h0C;
    localparam logic [4:0] ST_RST = 5'h0D;
    localparam int POS_W = 32;
    localparam int STAT_WBREAK = 0;
    localparam int STAT_PERR = 1;
    localparam int STAT_BUSY = 2;
    localparam int STAT_SLOW = 3;
    localparam int STAT_CNT_LSB = 8;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ = 250;
    localparam int CYCLE_US = 125;
    localparam int BIT_RATE_KBPS = 1000;
    localparam int MONO_US = 6;
    localparam int CYCLE_CLKS = CYCLE_US * CLK_MHZ;
    localparam int HALF_CLKS = (CLK_MHZ * 1000) / (2 * BIT_RATE_KBPS);
    localparam int MONO_CLKS = MONO_US * CLK_MHZ;

    // ****************************************************************
    // Frame layout decoded from the frame mode
    // ****************************************************************
    typedef struct packed {
        logic [1:0] free_cnt;
        logic par_en;
        logic par_odd;
        logic wb_en;
        logic valid;
    } frame_s;

    typedef enum logic [1:0] {PAR_OFF, PAR_ODD, PAR_EVEN} par_e;

endpackage : ssi_pkg

// file: verilog/ssi_cyclic_encoder_master.sv
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
// Notes on behaviour
// - Clock and data lines idle high between transfers.
// - Position decoded as binary or Gray per code selection.
// - Read starts every multiplier times 125 us; encoder refreshes much faster.
// - Wire-break check adds one clock after data and samples it.
// - Extra bit high flags wire break; low means line intact.
// - Frame mode 0001h drops wire-break check, one bit fewer.
// - Some frame modes clock in and evaluate a parity bit.
// - Special bits after data are clocked, sampled, ignored.
// - Read period equals multiplier times 125 us.
// - Longer read cycle allowed, flagged as degraded.
// - Cyclic readout enabled when encoder selection equals 2 and the frame mode is legal.
// - Multiturn bit count configurable, sent first.
// - Singleturn bit count configurable, follows multiturn bits.
// - Linear encoders handled exactly as rotary.
// - Multiturn count limited to 14.
// - Code select 0 binary, 1 Gray; Gray after reset.
// - Frame mode resets to 0000h: data plus wire-break bit.
module ssi_cyclic_encoder_master
    import ssi_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Encoder link
    output logic ssi_clk,
    input wire logic ssi_data,
    // Position output
    output logic [POS_W-1:0] decoded_position,
    output logic position_valid
);

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [3:0] encoder_type_select_q;
    logic position_code_select_q;
    logic [7:0] read_period_multiplier_q;
    logic [15:0] frame_mode_select_q;
    logic [4:0] multiturn_bit_count_q;
    logic [4:0] singleturn_bit_count_q;
    logic wbreak_q, perr_q;
    logic [15:0] frame_cnt_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] rd_mux;
    logic busy;

    // Single-cycle slave: no wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Capture write address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= hsel && htrans[1] && hwrite;
            wr_addr_q <= haddr;
        end
    end

    // Configuration writes in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            encoder_type_select_q <= SEL_RST;
            position_code_select_q <= CODE_GRAY;
            read_period_multiplier_q <= PER_RST;
            frame_mode_select_q <= MODE_RST;
            multiturn_bit_count_q <= MT_RST;
            singleturn_bit_count_q <= ST_RST;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                CTRL_OFS: begin
                    encoder_type_select_q <= hwdata[SEL_LSB +: 4];
                    position_code_select_q <= hwdata[CODE_BIT];
                    // Zero would stall readout, so it is held at one
                    read_period_multiplier_q <=
                        (hwdata[PER_LSB +: 8] == 8'h00) ? PER_RST
                        : hwdata[PER_LSB +: 8];
                    frame_mode_select_q <= hwdata[MODE_LSB +: 16];
                end
                CFG_OFS: begin
                    // Clamp so the frame stays within the cyclic limit
                    multiturn_bit_count_q <=
                        (hwdata[MT_LSB +: 5] > MT_MAX) ? MT_MAX
                        : hwdata[MT_LSB +: 5];
                    singleturn_bit_count_q <= hwdata[ST_LSB +: 5];
                end
                default: ;
            endcase
        end
    end

    // Read mux; reads take effect in the cycle after the address phase
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr)
            CTRL_OFS: begin
                rd_mux[SEL_LSB +: 4] = encoder_type_select_q;
                rd_mux[CODE_BIT] = position_code_select_q;
                rd_mux[PER_LSB +: 8] = read_period_multiplier_q;
                rd_mux[MODE_LSB +: 16] = frame_mode_select_q;
            end
            CFG_OFS: begin
                rd_mux[MT_LSB +: 5] = multiturn_bit_count_q;
                rd_mux[ST_LSB +: 5] = singleturn_bit_count_q;
            end
            STAT_OFS: begin
                rd_mux[STAT_WBREAK] = wbreak_q;
                rd_mux[STAT_PERR] = perr_q;
                rd_mux[STAT_BUSY] = busy;
                // Warn: control quality degrades above one period
                rd_mux[STAT_SLOW] = (read_period_multiplier_q != PER_RST);
                rd_mux[STAT_CNT_LSB +: 16] = frame_cnt_q;
            end
            POS_OFS: rd_mux = decoded_position;
            default: ;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

    // ****************************************************************
    // Frame mode decode
    // ****************************************************************
    // Mode table; reserved codes clear valid, so the readout halts
    frame_s fr;
    always_comb begin
        fr = '0;
        fr.valid = frame_mode_select_q inside {16'h0000, 16'h0001,
            16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0007,
            16'h000C, 16'h000D, 16'h000E, 16'h000F, 16'h001F, 16'h0020,
            16'h0021, 16'h0022};
        fr.wb_en = frame_mode_select_q inside {16'h0000, 16'h0002,
            16'h0003, 16'h0006, 16'h0007, 16'h000C, 16'h000D};
        fr.par_en = frame_mode_select_q inside {16'h0002, 16'h0003,
            16'h0004, 16'h0005, 16'h000C, 16'h000D, 16'h000E, 16'h000F};
        fr.par_odd = frame_mode_select_q inside {16'h0002, 16'h0003,
            16'h0004, 16'h0005};
        case (frame_mode_select_q)
            16'h0003, 16'h0005, 16'h0006, 16'h000D, 16'h000F,
            16'h001F: fr.free_cnt = 2'd1;
            16'h0007, 16'h0020: fr.free_cnt = 2'd2;
            16'h0021, 16'h0022: fr.free_cnt = 2'd3;
            default: fr.free_cnt = 2'd0;
        endcase
    end

    // ****************************************************************
    // Read period timer
    // ****************************************************************
    typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_MONO} state_e;
    state_e state_q;
    logic [15:0] tick_q;
    logic [7:0] per_cnt_q;
    logic start, enabled;

    // Cyclic readout runs only with the SSI selection and a legal mode
    assign enabled = (encoder_type_select_q == SEL_SSI) && fr.valid;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_q <= 16'h0000;
            per_cnt_q <= 8'h00;
        end else if (!enabled) begin
            tick_q <= 16'h0000;
            per_cnt_q <= 8'h00;
        end else if (tick_q == 16'(CYCLE_CLKS - 1)) begin
            tick_q <= 16'h0000;
            per_cnt_q <= (per_cnt_q + 8'h01 >= read_period_multiplier_q)
                ? 8'h00 : per_cnt_q + 8'h01;
        end else begin
            tick_q <= tick_q + 16'h0001;
        end
    end

    // A start that finds the link busy is skipped, never queued
    assign start = enabled && (tick_q == 16'h0000) && (per_cnt_q == 8'h00)
        && (state_q == ST_IDLE);

    // ****************************************************************
    // Link engine
    // ****************************************************************
    logic [2:0] din_sync_q;
    logic din;
    logic [10:0] tim_q;
    logic [5:0] bit_q;
    logic [5:0] nbits, ndata;
    logic [POS_W-1:0] shift_q;
    logic par_acc_q;
    logic [5:0] wb_idx, par_idx;

    // Three-stage sampler; value taken when last two stages agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            din_sync_q <= 3'b111;
            din <= 1'b1;
        end else begin
            din_sync_q <= {din_sync_q[1:0], ssi_data};
            if (din_sync_q[2] == din_sync_q[1]) begin
                din <= din_sync_q[2];
            end
        end
    end

    // Linear and rotary encoders share this one word layout
    assign ndata = 6'(multiturn_bit_count_q) +
        6'(singleturn_bit_count_q);
    assign par_idx = ndata + 6'(fr.free_cnt);
    assign wb_idx = par_idx + 6'(fr.par_en);
    assign nbits = wb_idx + 6'(fr.wb_en);
    assign busy = (state_q != ST_IDLE);

    // Bit clock at 1 Mbit/s; data sampled at the end of each high phase,
    // after the rising edge that shifts the bit out (the first shifts the MSB)
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
            tim_q <= 11'h000;
            bit_q <= 6'h00;
            ssi_clk <= 1'b1;
            shift_q <= '0;
            par_acc_q <= 1'b0;
            wbreak_q <= 1'b0;
            perr_q <= 1'b0;
            frame_cnt_q <= 16'h0000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    ssi_clk <= 1'b1;
                    if (start) begin
                        state_q <= ST_LOW;
                        ssi_clk <= 1'b0;
                        tim_q <= 11'h000;
                        bit_q <= 6'h00;
                        shift_q <= '0;
                        par_acc_q <= 1'b0;
                    end
                end
                ST_LOW: begin
                    if (tim_q == 11'(HALF_CLKS - 1)) begin
                        tim_q <= 11'h000;
                        ssi_clk <= 1'b1;
                        state_q <= ST_HIGH;
                    end else begin
                        tim_q <= tim_q + 11'h001;
                    end
                end
                ST_HIGH: begin
                    if (tim_q == 11'(HALF_CLKS - 1)) begin
                        tim_q <= 11'h000;
                        // Sample at the end of the high phase; the clock falls here except after the last bit
                        if (bit_q < ndata) begin
                            shift_q <= {shift_q[POS_W-2:0], din};
                            par_acc_q <= par_acc_q ^ din;
                        end else if (fr.par_en && bit_q == par_idx) begin
                            perr_q <= fr.par_odd ? (par_acc_q == din)
                                : (par_acc_q != din);
                        end else if (fr.wb_en && bit_q == wb_idx) begin
                            wbreak_q <= din;
                        end
                        // Free bits fall through unused
                        if (bit_q == nbits - 6'h01) begin
                            state_q <= ST_MONO;
                        end else begin
                            bit_q <= bit_q + 6'h01;
                            ssi_clk <= 1'b0;
                            state_q <= ST_LOW;
                        end
                    end else begin
                        tim_q <= tim_q + 11'h001;
                    end
                end
                ST_MONO: begin
                    ssi_clk <= 1'b1;
                    if (tim_q == 11'(MONO_CLKS - 1)) begin
                        state_q <= ST_IDLE;
                        frame_cnt_q <= frame_cnt_q + 16'h0001;
                    end else begin
                        tim_q <= tim_q + 11'h001;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Position decode
    // ****************************************************************
    logic [POS_W-1:0] gray_bin;
    for (genvar gi = 0; gi < POS_W; gi++) begin : g_gray
        assign gray_bin[gi] = ^(shift_q >> gi);
    end

    // Result published when the monoflop wait starts, after the last frame bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            decoded_position <= '0;
            position_valid <= 1'b0;
        end else begin
            position_valid <= 1'b0;
            if (state_q == ST_MONO && tim_q == 11'h000) begin
                decoded_position <= (position_code_select_q == CODE_BIN)
                    ? shift_q : gray_bin;
                position_valid <= 1'b1;
            end
        end
    end

endmodule : ssi_cyclic_encoder_master

// file: verif/ssi_master_chk.sv
`timescale 1ns/100ps
module ssi_master_chk
    import ssi_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Register bus
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Encoder link and result
    input wire logic ssi_clk,
    input wire logic ssi_data,
    input wire logic [POS_W-1:0] decoded_position,
    input wire logic position_valid
);
    // ****************************************************************
    // Helper counters
    // ****************************************************************
    logic clk_prev_q;
    logic [15:0] run_q;
    logic [31:0] since_q;
    logic seen_q;
    logic start_w;

    // A frame start is a fall after an idle at least one monoflop long
    assign start_w = clk_prev_q && !ssi_clk && run_q >= MONO_CLKS;

    // Length of the current level run; saturates so long idles stay big
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_prev_q <= 1'b1;
            run_q <= 16'hFFFF; // Idle since reset counts as a long idle
        end else begin
            clk_prev_q <= ssi_clk;
            if (ssi_clk != clk_prev_q) begin
                run_q <= 16'h0001;
            end else if (run_q != 16'hFFFF) begin
                run_q <= run_q + 16'h0001;
            end
        end
    end

    // Cycles since the last frame start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            since_q <= 32'h00000000;
            seen_q <= 1'b0;
        end else if (start_w) begin
            since_q <= 32'h00000001;
            seen_q <= 1'b1;
        end else begin
            since_q <= since_q + 32'h00000001;
        end
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_frame_end;
        ssi_clk && run_q >= 16'h007C && run_q <= 16'h0084;
    endsequence
    sequence s_quiet;
        ssi_clk [*8];
    endsequence

    property p_low_half;
        $rose(ssi_clk) |-> run_q == HALF_CLKS;
    endproperty
    a_low_half: assert property (p_low_half)
        else $error("serial clock low half has wrong length");
    property p_high_half;
        $fell(ssi_clk) |-> run_q == HALF_CLKS || run_q >= MONO_CLKS;
    endproperty
    a_high_half: assert property (p_high_half)
        else $error("serial clock high time neither half bit nor idle");
    property p_idle_high;
        !ssi_clk && !clk_prev_q |-> run_q < HALF_CLKS;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("serial clock rests low");
    property p_valid_end;
        position_valid |-> s_frame_end;
    endproperty
    a_valid_end: assert property (p_valid_end)
        else $error("result not one cycle after last sampled bit");
    property p_quiet;
        position_valid |=> s_quiet;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("serial clock restarted inside monoflop wait");
    property p_valid_pulse;
        position_valid |=> !position_valid;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("position strobe longer than one cycle");
    property p_pos_upd;
        $changed(decoded_position) |-> position_valid || $past(position_valid);
    endproperty
    a_pos_upd: assert property (p_pos_upd)
        else $error("position changed without strobe");
    property p_period;
        start_w && seen_q |-> since_q % CYCLE_CLKS == 0;
    endproperty
    a_period: assert property (p_period)
        else $error("frame start off the read period grid");
    property p_bus_ok;
        hsel && htrans[1] && hready |=> hreadyout && !hresp;
    endproperty
    a_bus_ok: assert property (p_bus_ok)
        else $error("bus transfer not answered OKAY at once");
endmodule : ssi_master_chk

// file: verif/ssi_encoder_model.sv
`timescale 1ns/100ps
module ssi_encoder_model #(
    parameter realtime MONO_NS = 6000.0
) (
    // Serial link
    input wire logic ssi_clk,
    output logic ssi_data,
    // Test controls
    input wire logic [31:0] pos_raw,
    input wire logic [5:0] nbits,
    input wire logic par_on,
    input wire logic par_odd,
    input wire logic par_flip,
    input wire logic wire_cut
);
    logic [31:0] lat;
    logic drv;
    logic in_frame;
    int k;
    realtime last_edge;

    initial begin
        drv = 1'b1;
        in_frame = 1'b0;
        k = 0;
        last_edge = 0.0;
    end

    // First fall of a frame freezes the position, refreshed every frame
    always @(negedge ssi_clk) begin
        last_edge = $realtime;
        if (!in_frame) begin
            in_frame = 1'b1;
            lat = pos_raw & ((32'h00000001 << nbits) - 32'h00000001);
            k = 0;
        end
    end

    // Each rise shifts the next bit out at once, MSB first
    always @(posedge ssi_clk) begin
        last_edge = $realtime;
        if (in_frame) begin
            if (k < int'(nbits)) begin
                drv = lat[int'(nbits) - 1 - k];
            end else if (k == int'(nbits) && par_on) begin
                drv = (^lat) ^ par_odd ^ par_flip;
            end else begin
                drv = 1'b0; // Extra clocks only see monoflop low
            end
            k++;
        end
    end

    // Monoflop expires after quiet clock; line returns to idle high
    always #100 begin
        if (in_frame && ssi_clk && $realtime - last_edge >= MONO_NS) begin
            in_frame = 1'b0;
            drv = 1'b1;
        end
    end

    // An open line is pulled high whatever the encoder drives
    assign ssi_data = wire_cut ? 1'b1 : drv;
endmodule : ssi_encoder_model

// file: verif/ssi_cyclic_encoder_master_bench.sv
`timescale 1ns/100ps
module ssi_cyclic_encoder_master_bench;
    import ssi_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, pos_raw, rd;
    logic ssi_clk, ssi_data, position_valid, par_on, par_flip, wire_cut;
    logic [POS_W-1:0] decoded_position;
    int err_total, n_tests, falls;

    ssi_cyclic_encoder_master ssi_cyclic_encoder_master_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ssi_clk(ssi_clk), .ssi_data(ssi_data),
        .decoded_position(decoded_position), .position_valid(position_valid));
    ssi_encoder_model ssi_encoder_model_i (
        .ssi_clk(ssi_clk), .ssi_data(ssi_data), .pos_raw(pos_raw),
        .nbits(6'h08), .par_on(par_on), .par_odd(1'b1),
        .par_flip(par_flip), .wire_cut(wire_cut));

    // ****************************************************************
    // Clock, edge counter and watchdog
    // ****************************************************************
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    always @(negedge ssi_clk) falls++;
    // Three read periods plus the last frame; a hang ends as a failure
    initial begin
        repeat (99000) @(posedge hclk);
        err_total++;
        test_done();
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task test_done;
        if (err_total == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Single word transfer; waits for ready in both phases
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 99);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 99);
        chk(32'(n < 99), 32'h00000001);
        rd = hrdata;
    endtask : ahb
    task rd_chk(input logic [7:0] a, input logic [31:0] mask, exp);
        ahb(1'b0, a, 32'h00000000);
        chk(rd & mask, exp);
    endtask : rd_chk
    // Waits for the strobe away from the edge that launches it, checks
    // word and edge count, then returns just after a rising edge
    task frame_chk(input logic [31:0] exp, input int nclk);
        int n;
        falls = 0;
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (position_valid !== 1'b1 && n < 40000);
        chk(32'(position_valid), 32'h00000001);
        chk(decoded_position, exp);
        chk(32'(falls), 32'(nclk));
        @(posedge hclk);
    endtask : frame_chk
    function automatic logic [7:0] gray8(input logic [7:0] g);
        gray8[7] = g[7];
        for (int i = 6; i >= 0; i--) gray8[i] = gray8[i + 1] ^ g[i];
    endfunction : gray8

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_regs;
        rd_chk(CTRL_OFS, 32'hFFFFFFFF, 32'h00000110);
        rd_chk(CFG_OFS, 32'hFFFFFFFF, 32'h00000D0C);
        rd_chk(8'h10, 32'hFFFFFFFF, 32'h00000000);
        ahb(1'b1, POS_OFS, 32'hFFFFFFFF);
        rd_chk(POS_OFS, 32'hFFFFFFFF, 32'h00000000);
        ahb(1'b1, CFG_OFS, 32'h0000061F);
        rd_chk(CFG_OFS, 32'hFFFFFFFF, 32'h0000060E);
        ahb(1'b1, CFG_OFS, 32'h00000602);
        ahb(1'b1, CTRL_OFS, 32'h00000112);
    endtask : t_regs
    // Gray word, healthy line, then a brief slow-period setting
    task t_gray;
        pos_raw <= 32'h000000B4;
        frame_chk({24'h000000, gray8(8'hB4)}, 9);
        rd_chk(STAT_OFS, 32'h0000000F, 32'h00000004);
        ahb(1'b1, CTRL_OFS, 32'h00000212);
        rd_chk(STAT_OFS, 32'h00000008, 32'h00000008);
        ahb(1'b1, CTRL_OFS, 32'h00000002);
        rd_chk(CTRL_OFS, 32'hFFFFFFFF, 32'h00000102);
    endtask : t_gray
    // Open data line in binary mode reads all ones and flags a break
    task t_break;
        wire_cut <= 1'b1;
        frame_chk(32'h000000FF, 9);
        rd_chk(STAT_OFS, 32'h0000000B, 32'h00000001);
    endtask : t_break
    // Odd parity plus break bit, encoder sends a wrong parity bit
    task t_parity;
        wire_cut <= 1'b0;
        par_on <= 1'b1;
        par_flip <= 1'b1;
        pos_raw <= 32'h0000005A;
        ahb(1'b1, CTRL_OFS, 32'h00020102);
        frame_chk(32'h0000005A, 10);
        rd_chk(STAT_OFS, 32'h00FFFF0F, 32'h00000206);
    endtask : t_parity
    // Two free bits after the data; the first carries a one, ignored
    task t_free;
        pos_raw <= 32'h0000003D;
        ahb(1'b1, CTRL_OFS, 32'h00200102);
        frame_chk(32'h0000003D, 10);
    endtask : t_free

    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h00000000;
        pos_raw = 32'h00000000; par_on = 1'b0; par_flip = 1'b0;
        wire_cut = 1'b0; err_total = 0; n_tests = 0; falls = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_gray();
        t_break();
        t_parity();
        t_free();
        test_done();
    end
endmodule : ssi_cyclic_encoder_master_bench

bind ssi_cyclic_encoder_master ssi_master_chk ssi_master_chk_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ssi_clk(ssi_clk), .ssi_data(ssi_data),
    .decoded_position(decoded_position), .position_valid(position_valid));
